// [rtl/pic_irq.sv]
/*
 * interrupt status and clear logic of a three-timer pwm unit.
 * assumes event inputs are one-cycle pulses from logic on CLK, and a
 * register master that never issues read and write strobes together.
 */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
module pic_irq (
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   // event pulses, one bit per timer, operator, fault or channel
   input wire logic [2:0] TIMER_STOP_EVENT,
   input wire logic [2:0] TIMER_ZERO_EVENT,
   input wire logic [2:0] TIMER_PERIOD_EVENT,
   input wire logic [2:0] FAULT_START_EVENT,
   input wire logic [2:0] FAULT_END_EVENT,
   input wire logic [2:0] OPERATOR_A_COMPARE_EVENT,
   input wire logic [2:0] OPERATOR_B_COMPARE_EVENT,
   input wire logic [2:0] FAULT_CYCLE_LIMIT_ACTION,
   input wire logic [2:0] FAULT_ONE_SHOT_ACTION,
   input wire logic [2:0] CAPTURE_EVENT,
   // register port
   input wire logic [11:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   // interrupt
   output logic PWM_IRQ
);
   import pic_pkg::*;

   // ****************************************
   // state
   // ****************************************
   logic [PIC_NSRC-1:0] raw;
   logic [PIC_NSRC-1:0] enable;
   logic [31:0] rdata;
   logic irq;
   logic [PIC_NSRC-1:0] next_raw;
   logic [PIC_NSRC-1:0] next_enable;
   logic [31:0] next_rdata;
   logic next_irq;
   logic [PIC_NSRC-1:0] events;
   logic [PIC_NSRC-1:0] clr;
   logic [PIC_NSRC-1:0] masked;

   // ****************************************
   // event gathering
   // ****************************************
   always_comb begin
      events = '0;
      events[PIC_BIT_STOP +: 3] = TIMER_STOP_EVENT;
      events[PIC_BIT_ZERO +: 3] = TIMER_ZERO_EVENT;
      events[PIC_BIT_PERIOD +: 3] = TIMER_PERIOD_EVENT;
      events[PIC_BIT_FSTART +: 3] = FAULT_START_EVENT;
      events[PIC_BIT_FEND +: 3] = FAULT_END_EVENT;
      events[PIC_BIT_OPA +: 3] = OPERATOR_A_COMPARE_EVENT;
      events[PIC_BIT_OPB +: 3] = OPERATOR_B_COMPARE_EVENT;
      events[PIC_BIT_CYCLE +: 3] = FAULT_CYCLE_LIMIT_ACTION;
      events[PIC_BIT_ONESHOT +: 3] = FAULT_ONE_SHOT_ACTION;
      events[PIC_BIT_CAP +: 3] = CAPTURE_EVENT;
   end

   // ****************************************
   // set checks
   // ****************************************
   // stop event sets
   a_stop_set: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && TIMER_STOP_EVENT[2]
      |=> raw[PIC_BIT_STOP+2])
      else $error("timer stop event lost");
   a_event_sets_bit: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && TIMER_ZERO_EVENT[1]
      |=> raw[PIC_BIT_ZERO+1])
      else $error("timer zero event lost");
   a_period_set: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && TIMER_PERIOD_EVENT[0]
      |=> raw[PIC_BIT_PERIOD])
      else $error("timer period event lost");
   a_fault_start_set: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && FAULT_START_EVENT[0]
      |=> raw[PIC_BIT_FSTART])
      else $error("fault start lost");
   a_fault_end_set: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && FAULT_END_EVENT[2]
      |=> raw[PIC_BIT_FEND+2])
      else $error("fault end lost");
   a_opa_set: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && OPERATOR_A_COMPARE_EVENT[1]
      |=> raw[PIC_BIT_OPA+1])
      else $error("operator A event lost");
   a_opb_set: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && OPERATOR_B_COMPARE_EVENT[2]
      |=> raw[PIC_BIT_OPB+2])
      else $error("operator B event lost");
   a_cycle_set: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && FAULT_CYCLE_LIMIT_ACTION[0]
      |=> raw[PIC_BIT_CYCLE])
      else $error("cycle-limit action lost");
   a_oneshot_set: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && FAULT_ONE_SHOT_ACTION[1]
      |=> raw[PIC_BIT_ONESHOT+1])
      else $error("one-shot action lost");
   a_capture_set: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && CAPTURE_EVENT[0]
      |=> raw[PIC_BIT_CAP])
      else $error("capture event lost");

   // clear word acts only on a write to its offset
   assign clr = (REG_WR && REG_ADDR == PIC_ADDR_CLEAR) ? REG_WDATA[PIC_NSRC-1:0] : '0;
   assign masked = raw & enable;

   // ****************************************
   // clear checks
   // ****************************************
   // stop bit clears
   a_clear_drops_bit: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && clr[PIC_BIT_STOP] && !events[PIC_BIT_STOP]
      |=> !raw[PIC_BIT_STOP])
      else $error("stop bit not cleared");
   a_zero_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && clr[PIC_BIT_ZERO+2] && !events[PIC_BIT_ZERO+2]
      |=> !raw[PIC_BIT_ZERO+2])
      else $error("zero bit not cleared");
   a_period_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && clr[PIC_BIT_PERIOD+1] && !events[PIC_BIT_PERIOD+1]
      |=> !raw[PIC_BIT_PERIOD+1])
      else $error("period bit not cleared");
   a_fstart_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && clr[PIC_BIT_FSTART+2] && !events[PIC_BIT_FSTART+2]
      |=> !raw[PIC_BIT_FSTART+2])
      else $error("fault start bit not cleared");
   a_fend_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && clr[PIC_BIT_FEND+1] && !events[PIC_BIT_FEND+1]
      |=> !raw[PIC_BIT_FEND+1])
      else $error("fault end bit not cleared");
   a_clear_wins_not: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && clr[PIC_BIT_FEND] && events[PIC_BIT_FEND]
      |=> raw[PIC_BIT_FEND])
      else $error("fault end lost under clear");
   a_clear_isolated: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && raw[PIC_BIT_OPA] && !clr[PIC_BIT_OPA]
      |=> raw[PIC_BIT_OPA])
      else $error("operator A bit dropped");
   a_opb_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && clr[PIC_BIT_OPB] && !events[PIC_BIT_OPB]
      |=> !raw[PIC_BIT_OPB])
      else $error("operator B bit not cleared");
   a_cycle_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && clr[PIC_BIT_CYCLE+2] && !events[PIC_BIT_CYCLE+2]
      |=> !raw[PIC_BIT_CYCLE+2])
      else $error("cycle-limit bit not cleared");
   a_oneshot_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && clr[PIC_BIT_ONESHOT] && !events[PIC_BIT_ONESHOT]
      |=> !raw[PIC_BIT_ONESHOT])
      else $error("one-shot bit not cleared");
   a_capture_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && clr[PIC_BIT_CAP+2] && !events[PIC_BIT_CAP+2]
      |=> !raw[PIC_BIT_CAP+2])
      else $error("capture bit not cleared");

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      // per-bit clear; a new event wins over its clear
      next_raw = (raw & ~clr) | events;
      next_enable = enable;
      if (REG_WR && REG_ADDR == PIC_ADDR_ENABLE) begin
         next_enable = REG_WDATA[PIC_NSRC-1:0];
      end
      next_rdata = PIC_RESET_WORD;
      if (REG_RD) begin
         case (REG_ADDR)
            PIC_ADDR_ENABLE: next_rdata = {2'h0, enable};
            PIC_ADDR_RAW: next_rdata = {2'h0, raw};
            PIC_ADDR_MASKED: next_rdata = {2'h0, masked};
            // clear word is write-only and reads as zero
            default: next_rdata = PIC_RESET_WORD;
         endcase
      end
      // irq from the next masked word so it tracks status
      next_irq = |(next_raw & next_enable);
   end

   // ****************************************
   // register port checks
   // ****************************************
   // masked status readback
   a_masked_read: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && REG_RD && REG_ADDR == PIC_ADDR_MASKED
      |=> REG_RDATA == {2'h0, $past(masked)})
      else $error("masked read wrong");
   a_raw_read: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && REG_RD && REG_ADDR == PIC_ADDR_RAW
      |=> REG_RDATA == {2'h0, $past(raw)})
      else $error("raw read wrong");
   a_enable_read: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && REG_RD && REG_ADDR == PIC_ADDR_ENABLE
      |=> REG_RDATA == {2'h0, $past(enable)})
      else $error("enable read wrong");
   a_rdata_one_cycle: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && !REG_RD
      |=> REG_RDATA == 32'h00000000)
      else $error("read data outside its cycle");
   a_clear_reads_zero: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && REG_RD && REG_ADDR == PIC_ADDR_CLEAR
      |=> REG_RDATA == 32'h00000000)
      else $error("clear word read nonzero");
   a_clear_keeps_enable: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && REG_WR && REG_ADDR == PIC_ADDR_CLEAR
      |=> enable == $past(enable))
      else $error("clear write moved enable");
   a_enable_write: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && REG_WR && REG_ADDR == PIC_ADDR_ENABLE
      |=> enable == $past(REG_WDATA[PIC_NSRC-1:0]))
      else $error("enable write lost");
   a_status_ro: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && REG_WR && events == '0
      && (REG_ADDR == PIC_ADDR_MASKED || REG_ADDR == PIC_ADDR_RAW)
      |=> raw == $past(raw) && enable == $past(enable))
      else $error("status word took a write");

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         raw <= '0;
         enable <= '0;
         rdata <= PIC_RESET_WORD;
         irq <= 1'h0;
      end else if (CLK_EN) begin
         raw <= next_raw;
         enable <= next_enable;
         rdata <= next_rdata;
         irq <= next_irq;
      end
   end

   assign REG_RDATA = rdata;
   assign PWM_IRQ = irq;

   // ****************************************
   // interrupt checks
   // ****************************************
   // irq is or
   a_irq_tracks_masked: assert property (@(posedge CLK) disable iff (SYS_RST)
      PWM_IRQ
      == |(raw & enable))
      else $error("irq differs from masked or");
   a_irq_on_event: assert property (@(posedge CLK) disable iff (SYS_RST)
      CLK_EN && |(events & enable) && !(REG_WR && REG_ADDR == PIC_ADDR_ENABLE)
      |=> PWM_IRQ)
      else $error("enabled event gave no irq");
   a_freeze_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
      !CLK_EN
      |=> $stable(raw) && $stable(enable) && $stable(REG_RDATA) && $stable(PWM_IRQ))
      else $error("state moved while clock enable low");
endmodule // pic_irq

// [rtl/pic_pkg.sv]
/*
 * package for the pwm interrupt status and clear block:
 * register offsets, bit layout of the thirty event sources, reset values.
 * assumes a plain register port with one word per offset.
 */
package pic_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [11:0] PIC_ADDR_RAW = 12'h114;
   localparam logic [11:0] PIC_ADDR_MASKED = 12'h118;
   localparam logic [11:0] PIC_ADDR_CLEAR = 12'h11C;
   localparam logic [11:0] PIC_ADDR_ENABLE = 12'h110;
   localparam int PIC_NSRC = 30;
   localparam logic [31:0] PIC_RESET_WORD = 32'h00000000;
   // ****************************************
   // bit positions, three sources per group
   // ****************************************
   localparam int PIC_BIT_STOP = 0;
   localparam int PIC_BIT_ZERO = 3;
   localparam int PIC_BIT_PERIOD = 6;
   localparam int PIC_BIT_FSTART = 9;
   localparam int PIC_BIT_FEND = 12;
   localparam int PIC_BIT_OPA = 15;
   localparam int PIC_BIT_OPB = 18;
   localparam int PIC_BIT_CYCLE = 21;
   localparam int PIC_BIT_ONESHOT = 24;
   localparam int PIC_BIT_CAP = 27;
endpackage

// [tb/pic_irq_test.sv]
/* bench for pic_irq: register tasks, event pulses, expected words.
   assumes one CLK domain and read data in the cycle after the strobe. */
`timescale 1ns/100ps
module pic_irq_test;
   import pic_pkg::*;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic clk_en = 1'h1;
   logic [29:0] ev = '0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h00000000;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic [31:0] rdata;
   logic irq;
   int errors = 0;
   int total_checks = 0;
   // ****************************************
   // clock and device
   // ****************************************
   initial begin
      forever #5 clk = ~clk;
   end
   pic_irq uut (.CLK(clk), .SYS_RST(rst), .CLK_EN(clk_en),
      .TIMER_STOP_EVENT(ev[2:0]), .TIMER_ZERO_EVENT(ev[5:3]), .TIMER_PERIOD_EVENT(ev[8:6]),
      .FAULT_START_EVENT(ev[11:9]), .FAULT_END_EVENT(ev[14:12]),
      .OPERATOR_A_COMPARE_EVENT(ev[17:15]), .OPERATOR_B_COMPARE_EVENT(ev[20:18]),
      .FAULT_CYCLE_LIMIT_ACTION(ev[23:21]), .FAULT_ONE_SHOT_ACTION(ev[26:24]),
      .CAPTURE_EVENT(ev[29:27]), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
      .REG_RD(rd), .REG_RDATA(rdata), .PWM_IRQ(irq));
   // ****************************************
   // access tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h wanted %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1;
      chk(rdata, exp);
   endtask
   // events land at the edge that ends the pulse cycle
   task automatic pulse(input logic [29:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= '0;
      #1;
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ****************************************
   // sequence
   // ****************************************
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd_reg(PIC_ADDR_MASKED, PIC_RESET_WORD);
      rd_reg(PIC_ADDR_ENABLE, 32'h00000000);
      pulse('1);
      chk({31'h0, irq}, 32'h0);
      rd_reg(PIC_ADDR_RAW, 32'h3FFFFFFF);
      rd_reg(PIC_ADDR_MASKED, 32'h00000000);
      wr_reg(PIC_ADDR_ENABLE, 32'h15555555);
      rd_reg(PIC_ADDR_MASKED, 32'h15555555);
      chk({31'h0, irq}, 32'h1);
      @(posedge clk);
      #1;
      chk(rdata, 32'h00000000);
      // service only part of the pending set
      wr_reg(PIC_ADDR_CLEAR, 32'h05555555);
      rd_reg(PIC_ADDR_MASKED, 32'h10000000);
      rd_reg(PIC_ADDR_RAW, 32'h3AAAAAAA);
      wr_reg(PIC_ADDR_CLEAR, 32'h3FFFFFFF);
      rd_reg(PIC_ADDR_RAW, 32'h00000000);
      chk({31'h0, irq}, 32'h0);
      wr_reg(PIC_ADDR_ENABLE, 32'h3FFFFFFF);
      for (int i = 0; i < PIC_NSRC; i++) begin
         pulse(30'h1 << i);
         rd_reg(PIC_ADDR_MASKED, 32'h1 << i);
         chk({31'h0, irq}, 32'h1);
         wr_reg(PIC_ADDR_CLEAR, 32'h1 << i);
         rd_reg(PIC_ADDR_MASKED, 32'h0);
      end
      // event and clear on one edge: the event must not be lost
      @(posedge clk);
      ev <= 30'h1000;
      addr <= PIC_ADDR_CLEAR;
      wdata <= 32'h00001000;
      wr <= 1'h1;
      @(posedge clk);
      ev <= '0;
      wr <= 1'h0;
      rd_reg(PIC_ADDR_MASKED, 32'h00001000);
      wr_reg(PIC_ADDR_MASKED, 32'h0);
      wr_reg(PIC_ADDR_RAW, 32'h0);
      rd_reg(PIC_ADDR_MASKED, 32'h00001000);
      rd_reg(PIC_ADDR_CLEAR, 32'h0);
      rd_reg(12'h200, 32'h0);
      @(posedge clk);
      clk_en <= 1'h0;
      pulse(30'h1);
      @(posedge clk);
      clk_en <= 1'h1;
      rd_reg(PIC_ADDR_RAW, 32'h00001000);
      @(posedge clk);
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      rd_reg(PIC_ADDR_RAW, PIC_RESET_WORD);
      chk({31'h0, irq}, 32'h0);
      complete_run();
   end
endmodule // pic_irq_test
